// ===== hw/clk_mgr_if.sv
// link between the reset sequencer and the clock source manager
`timescale 1ns/1ps
interface clk_mgr_if;
    logic restart;
    logic ext_edge;
    logic sel_ext;
    logic fail;

    modport mgr (input restart, input ext_edge, output sel_ext, output fail);
    modport seq (output restart, output ext_edge, input sel_ext, input fail);
endinterface

// ===== hw/clk_source_mgr.sv
// oscillator start-up delay, external clock selection and failure fallback
`timescale 1ns/1ps
module clk_source_mgr
    import crm_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // sequencer side
    clk_mgr_if.mgr    cm
);

    localparam int SW = $clog2(STARTUP_CYC);
    localparam int GW = $clog2(FAIL_WINDOW_CYC) + 1;
    localparam logic [SW-1:0] START_LAST = SW'(STARTUP_CYC - 1);
    localparam logic [GW-1:0] GAP_FULL   = GW'(FAIL_WINDOW_CYC);

    clk_state_t    state_r;
    clk_state_t    state_nxt;
    logic [SW-1:0] start_r;
    logic [SW-1:0] start_nxt;
    logic [GW-1:0] gap_r;
    logic [GW-1:0] gap_nxt;
    logic          fail_r;
    logic          fail_nxt;
    logic          ext_alive;

    // ***********************************************************
    // next state
    // ***********************************************************
    always_comb
    begin
        state_nxt = state_r;
        start_nxt = start_r;
        fail_nxt  = fail_r;
        ext_alive = (gap_r != GAP_FULL);
        // no external edge for a whole window counts as failure
        if (cm.ext_edge)
            gap_nxt = '0; // RQ5
        else if (gap_r != GAP_FULL)
            gap_nxt = gap_r + 1'b1; // RQ5
        else
            gap_nxt = gap_r;
        unique case (state_r)
            CS_START:
            begin
                if (start_r == START_LAST)
                    state_nxt = ext_alive ? CS_EXT : CS_INT; // RQ1 RQ2
                else
                    start_nxt = start_r + 1'b1; // RQ1
            end
            CS_INT:
            begin
                state_nxt = CS_INT;
            end
            CS_EXT:
            begin
                if (!ext_alive)
                begin
                    state_nxt = CS_INT; // RQ3
                    fail_nxt  = 1'b1; // RQ4
                end
            end
            default:
            begin
                state_nxt = CS_START;
            end
        endcase
        // a new reset sequence restarts on the internal oscillator
        if (cm.restart)
        begin
            state_nxt = CS_START; // RQ1
            start_nxt = '0;
            fail_nxt  = (state_r == CS_EXT) && !ext_alive;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_r <= CS_START;
            start_r <= '0;
            gap_r   <= GAP_FULL;
            fail_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            start_r <= start_nxt;
            gap_r   <= gap_nxt;
            fail_r  <= fail_nxt;
        end
    end

    assign cm.sel_ext = (state_r == CS_EXT);
    assign cm.fail    = fail_r;

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_startup_len;
        $rose(cm.sel_ext) |-> $past(start_r) == START_LAST;
    endproperty
    a_startup_len: assert property (p_startup_len) // RQ1
        else $error("external clock chosen before start-up ended");

    property p_fallback;
        cm.sel_ext && !cm.restart && gap_r == GAP_FULL
            |=> !cm.sel_ext && cm.fail;
    endproperty
    a_fallback: assert property (p_fallback) // RQ3
        else $error("no fallback to internal oscillator on failure");

    property p_fail_cause;
        $rose(cm.fail) |-> $past(cm.sel_ext) && $past(gap_r) == GAP_FULL;
    endproperty
    a_fail_cause: assert property (p_fail_cause) // RQ4
        else $error("failure flag set without a missing clock");

    property p_window;
        cm.sel_ext && !cm.restart && cm.ext_edge && gap_r != GAP_FULL
            |=> cm.sel_ext ##1 (cm.sel_ext || $past(cm.restart));
    endproperty
    a_window: assert property (p_window) // RQ5
        else $error("external clock dropped too early after an edge");

endmodule

// ===== hw/clock_reset_manager.sv
// clock source, reset sequencing, watchdog and interface strap sampling
//
// Notes on behaviour
// (RQ1) After any reset the logic runs on the internal oscillator for 1024 cycles.
// (RQ2) After start-up the external clock is chosen when it is running.
// (RQ3) A failing external clock drops the selection back to the internal one.
// (RQ4) That failure is reported as a status flag.
// (RQ5) Failure means no external edge within a window of internal cycles.
// (RQ6) A supply below threshold holds reset; rising above it starts the sequence.
// (RQ7) A low reset pin halts the logic while clock management keeps running.
// (RQ8) The reset pin acts only after staying low for at least 1 us.
// (RQ9) Reset holds until the pin is high and 4096 further cycles have passed.
// (RQ10) At release the processor starts fetching at address 0.
// (RQ11) Firmware must refresh the watchdog before it times out.
// (RQ12) A watchdog timeout runs a full reset sequence.
// (RQ13) The first strap low picks SPI; high defers to the second strap.
// (RQ14) With SPI not picked, the second strap picks I2C high and UART low.
// (RQ15) Straps are sampled at reset and only the picked interface is enabled.
`timescale 1ns/1ps
module clock_reset_manager
    import crm_pkg::*;
#(
    parameter int WDT_TIMEOUT = WDT_TIMEOUT_CYC
)
(
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // pins
    input  wire logic                    supply_ok_in,
    input  wire logic                    reset_pin_n_in,
    input  wire logic                    iface_strap_first_in,
    input  wire logic                    iface_strap_second_in,
    input  wire logic                    ext_osc_in,
    // processor side
    input  wire logic                    timeout_refresh_in,
    output logic                         sys_reset_out,
    output logic                         cpu_run_out,
    output logic [crm_pkg::BOOT_ADDR_W-1:0] fetch_addr_out,
    // clock status
    output logic                         clk_sel_ext_out,
    output logic                         ext_osc_fail_out,
    // interface enables
    output logic                         iface_spi_en_out,
    output logic                         iface_i2c_en_out,
    output logic                         iface_uart_en_out
);

    import crm_pkg::*;

    localparam int FW = $clog2(RST_FILT_CYC + 1);
    localparam int TW = $clog2(RST_TIMER_CYC);
    localparam int WW = $clog2(WDT_TIMEOUT + 1);
    localparam logic [FW-1:0] FILT_FULL  = FW'(RST_FILT_CYC);
    localparam logic [TW-1:0] TIMER_LAST = TW'(RST_TIMER_CYC - 1);
    localparam logic [WW-1:0] WDT_LAST   = WW'(WDT_TIMEOUT - 1);

    clk_mgr_if cm ();

    // ***********************************************************
    // pin synchronisers
    // ***********************************************************
    logic [PIN_N-1:0] sync1_r;
    logic [PIN_N-1:0] sync2_r;
    logic             xosc3_r;
    logic [PIN_N-1:0] pins;

    assign pins = {ext_osc_in, iface_strap_second_in, iface_strap_first_in,
                   reset_pin_n_in, supply_ok_in};

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sync1_r <= SYNC_RESET;
            sync2_r <= SYNC_RESET;
            xosc3_r <= 1'b0;
        end
        else
        begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            xosc3_r <= sync2_r[PIN_XOSC];
        end
    end

    assign cm.ext_edge = sync2_r[PIN_XOSC] & ~xosc3_r;

    clk_source_mgr u_clk_source_mgr (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .cm       (cm.mgr)
    );

    // ***********************************************************
    // reset sequencer, filter, watchdog, straps
    // ***********************************************************
    rst_state_t             state_r;
    rst_state_t             state_nxt;
    logic [FW-1:0]          filt_r;
    logic [FW-1:0]          filt_nxt;
    logic [TW-1:0]          timer_r;
    logic [TW-1:0]          timer_nxt;
    logic [WW-1:0]          wdt_r;
    logic [WW-1:0]          wdt_nxt;
    iface_t                 iface_r;
    iface_t                 iface_nxt;
    logic [BOOT_ADDR_W-1:0] fetch_r;
    logic [BOOT_ADDR_W-1:0] fetch_nxt;
    logic                   por_cause;
    logic                   pin_cause;
    logic                   wdt_cause;
    logic                   cause;

    assign por_cause = ~sync2_r[PIN_SUPPLY]; // RQ6
    assign pin_cause = (filt_r == FILT_FULL); // RQ8
    assign wdt_cause = (state_r == RS_RUN) && (wdt_r == WDT_LAST); // RQ12
    assign cause     = por_cause | pin_cause | wdt_cause;

    always_comb
    begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        iface_nxt = iface_r;
        fetch_nxt = fetch_r;
        // pin must stay low for the full filter time
        if (sync2_r[PIN_RST_N])
            filt_nxt = '0; // RQ8
        else if (filt_r != FILT_FULL)
            filt_nxt = filt_r + 1'b1; // RQ8
        else
            filt_nxt = filt_r;
        // firmware refresh restarts the watchdog
        if (state_r != RS_RUN || timeout_refresh_in)
            wdt_nxt = '0; // RQ11
        else
            wdt_nxt = wdt_r + 1'b1;
        unique case (state_r)
            RS_HOLD:
            begin
                if (!cause)
                begin
                    state_nxt = RS_TIMER; // RQ9
                    timer_nxt = '0;
                end
            end
            RS_TIMER:
            begin
                if (cause)
                    state_nxt = RS_HOLD; // RQ9
                else if (timer_r == TIMER_LAST)
                begin
                    state_nxt = RS_RUN; // RQ9
                    fetch_nxt = BOOT_ADDR; // RQ10
                    if (!sync2_r[PIN_STRAP0])
                        iface_nxt = IF_SPI; // RQ13
                    else if (sync2_r[PIN_STRAP1])
                        iface_nxt = IF_I2C; // RQ14
                    else
                        iface_nxt = IF_UART; // RQ14
                end
                else
                    timer_nxt = timer_r + 1'b1;
            end
            RS_RUN:
            begin
                if (cause)
                begin
                    state_nxt = RS_HOLD; // RQ6 RQ7 RQ12
                    iface_nxt = IF_NONE;
                end
            end
            default:
            begin
                state_nxt = RS_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_r <= RS_HOLD;
            filt_r  <= '0;
            timer_r <= '0;
            wdt_r   <= '0;
            iface_r <= IF_NONE;
            fetch_r <= BOOT_ADDR;
        end
        else
        begin
            state_r <= state_nxt;
            filt_r  <= filt_nxt;
            timer_r <= timer_nxt;
            wdt_r   <= wdt_nxt;
            iface_r <= iface_nxt; // RQ15
            fetch_r <= fetch_nxt;
        end
    end

    // every new reset sequence restarts the oscillator start-up
    assign cm.restart = (state_r != RS_HOLD) && (state_nxt == RS_HOLD); // RQ1

    assign sys_reset_out     = (state_r != RS_RUN); // RQ7
    assign cpu_run_out       = (state_r == RS_RUN);
    assign fetch_addr_out    = fetch_r;
    assign clk_sel_ext_out   = cm.sel_ext; // RQ2
    assign ext_osc_fail_out  = cm.fail; // RQ4
    assign iface_spi_en_out  = (iface_r == IF_SPI);
    assign iface_i2c_en_out  = (iface_r == IF_I2C);
    assign iface_uart_en_out = (iface_r == IF_UART);

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_timer_end;
        state_r == RS_TIMER && timer_r == TIMER_LAST && !cause;
    endsequence

    property p_release;
        $rose(cpu_run_out) |-> $past(state_r) == RS_TIMER
            && $past(timer_r) == TIMER_LAST;
    endproperty
    a_release: assert property (p_release) // RQ9
        else $error("reset released before the timer ran out");

    property p_boot;
        s_timer_end |=> cpu_run_out && fetch_addr_out == BOOT_ADDR;
    endproperty
    a_boot: assert property (p_boot) // RQ10
        else $error("processor not started at the boot address");

    property p_por;
        por_cause |=> sys_reset_out [*2];
    endproperty
    a_por: assert property (p_por) // RQ6
        else $error("low supply did not hold reset");

    property p_pin_halt;
        pin_cause |=> sys_reset_out && !iface_spi_en_out
            && !iface_i2c_en_out && !iface_uart_en_out;
    endproperty
    a_pin_halt: assert property (p_pin_halt) // RQ7
        else $error("reset pin did not halt the logic");

    property p_filter;
        $rose(pin_cause) |-> $past(filt_r) == FILT_FULL - 1'b1
            && !$past(sync2_r[PIN_RST_N]);
    endproperty
    a_filter: assert property (p_filter) // RQ8
        else $error("reset pin acted before the filter time");

    property p_wdt;
        wdt_cause |=> sys_reset_out ##1 state_r == RS_TIMER;
    endproperty
    a_wdt: assert property (p_wdt) // RQ12
        else $error("watchdog timeout did not start a reset sequence");

    property p_strap;
        s_timer_end |=> iface_r == ($past(sync2_r[PIN_STRAP0])
            ? ($past(sync2_r[PIN_STRAP1]) ? IF_I2C : IF_UART) : IF_SPI);
    endproperty
    a_strap: assert property (p_strap) // RQ13
        else $error("interface does not match the sampled straps");

    property p_iface_hold;
        cpu_run_out && $past(cpu_run_out) |-> $stable(iface_r)
            && $onehot({iface_spi_en_out, iface_i2c_en_out,
                        iface_uart_en_out});
    endproperty
    a_iface_hold: assert property (p_iface_hold) // RQ15
        else $error("interface choice changed while running");

endmodule

// ===== hw/crm_pkg.sv
// constants and types shared by the clock and reset manager files
package crm_pkg;

    // ***********************************************************
    // timing
    // ***********************************************************
    localparam int CLK_FREQ_MHZ    = 250;
    localparam int STARTUP_CYC     = 1024;
    localparam int RST_FILT_NS     = 1000;
    localparam int RST_FILT_CYC    = (RST_FILT_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int RST_TIMER_CYC   = 4096;
    localparam int FAIL_WINDOW_CYC = 64;
    localparam int WDT_TIMEOUT_CYC = 1048576;

    // ***********************************************************
    // boot and pin indices
    // ***********************************************************
    localparam int                    BOOT_ADDR_W = 16;
    localparam logic [BOOT_ADDR_W-1:0] BOOT_ADDR  = 16'h0000;
    localparam int PIN_N      = 5;
    localparam int PIN_SUPPLY = 0;
    localparam int PIN_RST_N  = 1;
    localparam int PIN_STRAP0 = 2;
    localparam int PIN_STRAP1 = 3;
    localparam int PIN_XOSC   = 4;
    localparam logic [PIN_N-1:0] SYNC_RESET = 5'h02;

    // ***********************************************************
    // state and mode types
    // ***********************************************************
    typedef enum logic [1:0] {
        RS_HOLD  = 2'b00,
        RS_TIMER = 2'b01,
        RS_RUN   = 2'b10
    } rst_state_t;

    typedef enum logic [1:0] {
        CS_START = 2'b00,
        CS_INT   = 2'b01,
        CS_EXT   = 2'b10
    } clk_state_t;

    typedef enum logic [1:0] {
        IF_NONE = 2'b00,
        IF_SPI  = 2'b01,
        IF_I2C  = 2'b10,
        IF_UART = 2'b11
    } iface_t;

endpackage

// ===== verification/board_model.sv
// board side model: supply, reset pin, straps and external oscillator
`timescale 1ns/1ps
module board_model
(
    // controls from the bench
    input  wire logic osc_on_in,
    input  wire logic supply_up_in,
    input  wire logic pin_low_in,
    input  wire logic strap_a_in,
    input  wire logic strap_b_in,
    // pins toward the device
    output logic      ext_osc_out,
    output logic      supply_ok_out,
    output logic      reset_pin_n_out,
    output logic      strap_first_out,
    output logic      strap_second_out
);
    // ***********************************************************
    // pins
    // ***********************************************************
    logic osc_r = 1'h0;

    // 20 MHz crystal, phase unrelated to the core clock; dead one sits low
    always
    begin
        #25;
        osc_r = osc_on_in ? ~osc_r : 1'h0;
    end

    assign ext_osc_out      = osc_r;
    assign supply_ok_out    = supply_up_in;
    assign reset_pin_n_out  = ~pin_low_in;
    assign strap_first_out  = strap_a_in;
    assign strap_second_out = strap_b_in;
endmodule

// ===== verification/tb.sv
// self-checking bench for the clock and reset manager
`timescale 1ns/1ps
module tb;
    import crm_pkg::*;
    // ***********************************************************
    // signals
    // ***********************************************************
    localparam int WDT_SIM = 64;
    localparam int LIMIT   = 40000;
    logic        clk_in;
    logic        reset_in;
    logic        refresh;
    logic        osc_on;
    logic        supply_up;
    logic        pin_low;
    logic        strap_a;
    logic        strap_b;
    logic        ext_osc;
    logic        supply_ok;
    logic        pin_n;
    logic        strap1;
    logic        strap2;
    logic        sys_reset;
    logic        cpu_run;
    logic [15:0] fetch_addr;
    logic        sel_ext;
    logic        osc_fail;
    logic        en_spi;
    logic        en_i2c;
    logic        en_uart;
    int          err_count;
    int          check_count;
    int          cyc;

    board_model board (.osc_on_in(osc_on), .supply_up_in(supply_up),
        .pin_low_in(pin_low), .strap_a_in(strap_a), .strap_b_in(strap_b),
        .ext_osc_out(ext_osc), .supply_ok_out(supply_ok),
        .reset_pin_n_out(pin_n), .strap_first_out(strap1),
        .strap_second_out(strap2));

    clock_reset_manager #(.WDT_TIMEOUT(WDT_SIM)) dut (.clk_in(clk_in),
        .reset_in(reset_in), .supply_ok_in(supply_ok),
        .reset_pin_n_in(pin_n), .iface_strap_first_in(strap1),
        .iface_strap_second_in(strap2), .ext_osc_in(ext_osc),
        .timeout_refresh_in(refresh), .sys_reset_out(sys_reset),
        .cpu_run_out(cpu_run), .fetch_addr_out(fetch_addr),
        .clk_sel_ext_out(sel_ext), .ext_osc_fail_out(osc_fail),
        .iface_spi_en_out(en_spi), .iface_i2c_en_out(en_i2c),
        .iface_uart_en_out(en_uart));

    // ***********************************************************
    // helpers
    // ***********************************************************
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task check(input string what, input logic [15:0] seen,
               input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // counts edges until the processor runs, judged against a window
    task run_wait(input int lo);
        int n;
        n = 0;
        while (cpu_run !== 1'h1 && n < lo + 13)
        begin
            tick(1);
            n++;
        end
        check("run delay", 16'(n >= lo && n <= lo + 12), 16'h0001);
    endtask

    function automatic logic [15:0] ens();
        return 16'({en_spi, en_i2c, en_uart});
    endfunction

    // ***********************************************************
    // scenarios
    // ***********************************************************
    task t_boot;
        @(posedge clk_in);
        reset_in <= 1'h0;
        tick(1000);
        check("sel early", 16'(sel_ext), 16'h0000);
        tick(40);
        check("sel ext", 16'(sel_ext), 16'h0001);
        check("held", 16'(sys_reset), 16'h0001);
        run_wait(RST_TIMER_CYC - 1040);
        check("fetch", fetch_addr, BOOT_ADDR);
        check("spi", ens(), 16'h0004);
        $display("test boot done");
    endtask

    task t_fail;
        @(posedge clk_in);
        osc_on <= 1'h0;
        tick(40);
        check("sel kept", 16'(sel_ext), 16'h0001);
        tick(60);
        check("fallback", 16'(sel_ext), 16'h0000);
        check("fail", 16'(osc_fail), 16'h0001);
        @(posedge clk_in);
        osc_on <= 1'h1;
        tick(200);
        check("no return", 16'(sel_ext), 16'h0000);
        check("sticky", 16'(osc_fail), 16'h0001);
        check("running", 16'(cpu_run), 16'h0001);
        $display("test fail done");
    endtask

    task t_pin;
        logic [2:0] a_tab;
        logic [2:0] b_tab;
        logic [15:0] exp_tab [3];
        a_tab = 3'h6;
        b_tab = 3'h3;
        exp_tab = '{16'h0004, 16'h0002, 16'h0001};
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_in);
            pin_low <= 1'h1;
            strap_a <= a_tab[k];
            strap_b <= b_tab[k];
            tick(k == 0 ? 1400 : 300);
            check("pin reset", 16'(sys_reset), 16'h0001);
            check("halted", ens(), 16'h0000);
            if (k == 0)
                check("clk mgr live", 16'(sel_ext), 16'h0001);
            @(posedge clk_in);
            pin_low <= 1'h0;
            run_wait(RST_TIMER_CYC);
            check("iface", ens(), exp_tab[k]);
            check("fetch", fetch_addr, BOOT_ADDR);
            check("fail clr", 16'(osc_fail), 16'h0000);
            @(posedge clk_in);
            strap_a <= ~a_tab[k];
            strap_b <= ~b_tab[k];
            tick(10);
            check("iface kept", ens(), exp_tab[k]);
        end
        $display("test pin done");
    endtask

    task t_glitch;
        @(posedge clk_in);
        pin_low <= 1'h1;
        tick(200);
        check("no glitch", 16'(sys_reset), 16'h0000);
        @(posedge clk_in);
        pin_low <= 1'h0;
        tick(20);
        check("still run", 16'(cpu_run), 16'h0001);
        $display("test glitch done");
    endtask

    task t_supply;
        @(posedge clk_in);
        supply_up <= 1'h0;
        osc_on <= 1'h0;
        tick(8);
        check("por", 16'(sys_reset), 16'h0001);
        @(posedge clk_in);
        supply_up <= 1'h1;
        run_wait(RST_TIMER_CYC);
        check("no ext", 16'(sel_ext), 16'h0000);
        check("no fail", 16'(osc_fail), 16'h0000);
        @(posedge clk_in);
        osc_on <= 1'h1;
        $display("test supply done");
    endtask

    task t_wdt;
        int n;
        n = 0;
        repeat (20)
        begin
            @(posedge clk_in);
            refresh <= 1'h1;
            @(posedge clk_in);
            refresh <= 1'h0;
            tick(8);
        end
        check("refreshed", 16'(cpu_run), 16'h0001);
        while (sys_reset !== 1'h1 && n < 100)
        begin
            tick(1);
            n++;
        end
        check("wdt delay", 16'(n >= 48 && n <= 68), 16'h0001);
        @(posedge clk_in);
        refresh <= 1'h1;
        run_wait(RST_TIMER_CYC);
        check("sel again", 16'(sel_ext), 16'h0001);
        $display("test watchdog done");
    endtask

    // ***********************************************************
    // clock, timeout and sequence
    // ***********************************************************
    initial
    begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            err_count++;
            finish_test;
        end
    end

    initial
    begin
        err_count = 0;
        check_count = 0;
        cyc = 0;
        reset_in = 1'h1;
        refresh = 1'h1;
        osc_on = 1'h1;
        supply_up = 1'h1;
        pin_low = 1'h0;
        strap_a = 1'h0;
        strap_b = 1'h0;
        repeat (20) @(posedge clk_in);
        t_boot;
        t_fail;
        t_pin;
        t_glitch;
        t_supply;
        t_wdt;
        finish_test;
    end
endmodule
